// file: rtl/dco_cond_eval.v
// condition code evaluator against status flags and user pins
`timescale 1ns/1ps
`include "dco_defs.vh"
module dco_cond_eval (
  input wire [3:0] cond,
  input wire [7:0] flags,
  input wire user_input_pin_zero,
  input wire user_input_pin_one,
  output reg cond_true
);
  wire z;
  wire m;
  assign z = flags[`DCO_FL_Z];
  assign m = flags[`DCO_FL_M];
  always @*
  begin
    case (cond)
      `DCO_C_TRUE: cond_true = 1'b1;
      `DCO_C_ZERO: cond_true = z;
      `DCO_C_NZERO: cond_true = ~z;
      `DCO_C_POS: cond_true = ~m & ~z;
      `DCO_C_NNEG: cond_true = ~m;
      `DCO_C_NEG: cond_true = m;
      `DCO_C_NPOS: cond_true = m | z;
      `DCO_C_NNORM: cond_true = ~flags[`DCO_FL_N];
      `DCO_C_RCLR: cond_true = ~flags[`DCO_FL_R];
      `DCO_C_OVF: cond_true = flags[`DCO_FL_V];
      `DCO_C_CARRY: cond_true = flags[`DCO_FL_C];
      `DCO_C_EXT: cond_true = flags[`DCO_FL_E];
      `DCO_C_LIM: cond_true = flags[`DCO_FL_L];
      `DCO_C_PIN0_LO: cond_true = ~user_input_pin_zero;
      `DCO_C_PIN0_HI: cond_true = user_input_pin_zero;
      // pin one has only a high test; there is no low code
      `DCO_C_PIN1_HI: cond_true = user_input_pin_one;
      default: cond_true = 1'b0;
    endcase
  end
endmodule

// file: rtl/dco_defs.vh
// register offsets, field positions, codes and reset values
`ifndef DCO_DEFS_VH
`define DCO_DEFS_VH
`define DCO_ADDR_INSTR 8'h00
`define DCO_ADDR_FLAGS 8'h04
`define DCO_ADDR_FLAGCFG 8'h08
`define DCO_ADDR_MODCFG 8'h0C
`define DCO_ADDR_STATE 8'h10
`define DCO_ADDR_ACC0_HL 8'h14
`define DCO_ADDR_ACC0_EXT 8'h18
`define DCO_ADDR_ACC1_HL 8'h1C
`define DCO_ADDR_ACC1_EXT 8'h20
`define DCO_ADDR_SHADOW 8'h24
`define DCO_ADDR_PTR_BASE 8'h40
`define DCO_ADDR_PTR_LAST 8'h54
// instruction word fields
`define DCO_F_COND_LSB 0
`define DCO_F_OP_LSB 4
`define DCO_F_SEL_LSB 7
`define DCO_F_OPTION 10
`define DCO_F_MODK_LSB 11
`define DCO_F_DATA_LSB 16
// operation codes
`define DCO_OP_NOP 3'h0
`define DCO_OP_MOVH 3'h1
`define DCO_OP_RETI 3'h2
`define DCO_OP_MODR 3'h3
`define DCO_OP_FLAGS 3'h4
// post-modify kinds
`define DCO_MOD_NONE 2'h0
`define DCO_MOD_INC 2'h1
`define DCO_MOD_DEC 2'h2
`define DCO_MOD_STEP 2'h3
// flag positions inside the flag word
`define DCO_FL_Z 0
`define DCO_FL_M 1
`define DCO_FL_N 2
`define DCO_FL_V 3
`define DCO_FL_C 4
`define DCO_FL_E 5
`define DCO_FL_L 6
`define DCO_FL_R 7
// per-flag update mode, two bits per flag
`define DCO_FM_KEEP 2'h0
`define DCO_FM_AFFECT 2'h1
`define DCO_FM_CLR 2'h2
`define DCO_FM_SET 2'h3
// condition codes
`define DCO_C_TRUE 4'h0
`define DCO_C_ZERO 4'h1
`define DCO_C_NZERO 4'h2
`define DCO_C_POS 4'h3
`define DCO_C_NNEG 4'h4
`define DCO_C_NEG 4'h5
`define DCO_C_NPOS 4'h6
`define DCO_C_NNORM 4'h7
`define DCO_C_OVF 4'h8
`define DCO_C_CARRY 4'h9
`define DCO_C_EXT 4'hA
`define DCO_C_LIM 4'hB
`define DCO_C_RCLR 4'hC
`define DCO_C_PIN0_LO 4'hD
`define DCO_C_PIN0_HI 4'hE
`define DCO_C_PIN1_HI 4'hF
// reset values
`define DCO_RST_FLAGS 8'h00
`define DCO_RST_MODSIZE 9'h000
`define DCO_RESP_OKAY 2'h0
`define DCO_RESP_SLVERR 2'h2
`endif

// file: rtl/dco_top.v
// condition, option field and flag update logic behind an axi4-lite port
// Function
// - keep-extension move into accumulator high leaves extension bits
// - plain move into accumulator high sign-extends into extension bits
// - interrupt return with context option swaps the context
// - interrupt return without context option swaps nothing
// - modulo bypass on pointer modify ignores the pointer's modulo bit
// - pointer modify without bypass uses modulo only if bit permits
// - always true; zero, nonzero, positive, nonnegative tests on z, m
// - negative is m set; nonpositive is m or z set
// - not-normalised is n clear; round-clear is r clear
// - overflow code is v set; carry code is c set
// - extension code is e set; limit code is l set
// - pin zero gives one code for low, one for high
// - pin one has only a high code
// - affected z, m, n follow the result, others take flag config bits 23:16; unaffected flags hold
// - forced flag entries set or clear regardless of operands
// - pointer modulo only with its own enable bit, bypass excepted
`timescale 1ns/1ps
`include "dco_defs.vh"
module dco_top #(
  parameter EXT_W = 4,
  parameter NPTR = 6
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire user_input_pin_zero,
  input wire user_input_pin_one
);
  // pins: three sync flops and one output flop each, a change counts once the last two sync flops agree
  reg [2:0] pin0_sync_q;
  reg [2:0] pin1_sync_q;
  reg pin0_q;
  reg pin1_q;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin0_sync_q <= 3'h0;
      pin1_sync_q <= 3'h0;
      pin0_q <= 1'b0;
      pin1_q <= 1'b0;
    end
    else
    begin
      pin0_sync_q <= {pin0_sync_q[1:0], user_input_pin_zero};
      pin1_sync_q <= {pin1_sync_q[1:0], user_input_pin_one};
      if (pin0_sync_q[1] == pin0_sync_q[2])
        pin0_q <= pin0_sync_q[2];
      if (pin1_sync_q[1] == pin1_sync_q[2])
        pin1_q <= pin1_sync_q[2];
    end
  end

  // architectural state
  reg [7:0] flags_q;
  reg [7:0] shadow_q;
  reg [23:0] flagcfg_q;
  reg [NPTR-1:0] pointer_modulo_enable_bit_q;
  reg [8:0] modsize_q;
  reg [6:0] step_q;
  reg [15:0] address_pointer_q [0:NPTR-1];
  reg [15:0] ptr_bank_q;
  reg [15:0] acc_hi_q [0:1];
  reg [15:0] acc_lo_q [0:1];
  reg [EXT_W-1:0] accum_extension_bits_q [0:1];
  reg [31:0] instr_q;
  reg exec_q;
  reg last_cond_q;
  reg [7:0] exec_cnt_q;
  reg [7:0] ctx_cnt_q;

  wire cond_true;
  dco_cond_eval u_cond (
    .cond(instr_q[`DCO_F_COND_LSB +: 4]),
    .flags(flags_q),
    .user_input_pin_zero(pin0_q),
    .user_input_pin_one(pin1_q),
    .cond_true(cond_true)
  );

  wire [2:0] op;
  wire [2:0] sel;
  wire option;
  wire [1:0] modk;
  wire [15:0] data;
  assign op = instr_q[`DCO_F_OP_LSB +: 3];
  assign sel = instr_q[`DCO_F_SEL_LSB +: 3];
  assign option = instr_q[`DCO_F_OPTION];
  assign modk = instr_q[`DCO_F_MODK_LSB +: 2];
  assign data = instr_q[`DCO_F_DATA_LSB +: 16];

  // post-modify; modulo wraps the low nine bits inside the modulo size
  function [15:0] post_mod;
    input [15:0] ptr;
    input [1:0] kind;
    input [6:0] step;
    input use_mod;
    input [8:0] msize;
    reg [15:0] delta;
    reg [15:0] plain;
    reg [9:0] low;
    begin
      case (kind)
        `DCO_MOD_INC: delta = 16'h0001;
        `DCO_MOD_DEC: delta = 16'hFFFF;
        `DCO_MOD_STEP: delta = {{9{step[6]}}, step};
        default: delta = 16'h0000;
      endcase
      plain = ptr + delta;
      low = {1'b0, ptr[8:0]} + {delta[9], delta[8:0]};
      if (!use_mod || msize == 9'h000)
        post_mod = plain;
      else if (low[9])
        post_mod = {ptr[15:9], low[8:0] + msize};
      else if (low[8:0] >= msize)
        post_mod = {ptr[15:9], low[8:0] - msize};
      else
        post_mod = {ptr[15:9], low[8:0]};
    end
  endfunction

  // next flag word from per-flag modes and the result
  function [7:0] upd_flags;
    input [7:0] old;
    input [23:0] cfg;
    input [15:0] res;
    reg [7:0] calc;
    integer i;
    begin
      calc = cfg[23:16];
      calc[`DCO_FL_Z] = (res == 16'h0000);
      calc[`DCO_FL_M] = res[15];
      calc[`DCO_FL_N] = (res == 16'h0000) | (res[15] ^ res[14]);
      for (i = 0; i < 8; i = i + 1)
      begin
        case (cfg[2*i +: 2])
          `DCO_FM_AFFECT: upd_flags[i] = calc[i];
          `DCO_FM_CLR: upd_flags[i] = 1'b0;
          `DCO_FM_SET: upd_flags[i] = 1'b1;
          default: upd_flags[i] = old[i];
        endcase
      end
    end
  endfunction

  // byte-lane merge for writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      for (b = 0; b < 4; b = b + 1)
        merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // axi write side: one write in flight
  reg aw_full_q;
  reg w_full_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire do_wr;
  wire [7:0] ptr_off;
  wire wr_ptr;
  wire [2:0] wr_idx;
  assign do_wr = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign ptr_off = awaddr_q - `DCO_ADDR_PTR_BASE;
  assign wr_ptr = awaddr_q >= `DCO_ADDR_PTR_BASE &&
    awaddr_q <= `DCO_ADDR_PTR_LAST && awaddr_q[1:0] == 2'h0;
  assign wr_idx = ptr_off[4:2];

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `DCO_ADDR_SHADOW ||
        (a >= `DCO_ADDR_PTR_BASE && a <= `DCO_ADDR_PTR_LAST));
    end
  endfunction

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DCO_RESP_OKAY;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_q) ? `DCO_RESP_OKAY : `DCO_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // execution and register writes; the instruction runs the cycle after
  // its word lands, so a bus write and execution never touch one register
  // in the same cycle: the pending write answer holds do_wr low then
  integer k;
  wire ptr_mod_on;
  wire [15:0] ptr_next;
  assign ptr_mod_on = ~option & pointer_modulo_enable_bit_q[sel];
  assign ptr_next = post_mod(address_pointer_q[sel], modk, step_q,
    ptr_mod_on, modsize_q);
  wire [31:0] wd;
  assign wd = wdata_q;
  // merged words are cut to the register widths below
  wire [31:0] cfg_mrg;
  wire [31:0] acc0_mrg;
  wire [31:0] acc1_mrg;
  assign cfg_mrg = merge({8'h00, flagcfg_q}, wd, wstrb_q);
  assign acc0_mrg = merge({acc_hi_q[0], acc_lo_q[0]}, wd, wstrb_q);
  assign acc1_mrg = merge({acc_hi_q[1], acc_lo_q[1]}, wd, wstrb_q);
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags_q <= `DCO_RST_FLAGS;
      shadow_q <= `DCO_RST_FLAGS;
      flagcfg_q <= 24'h000000;
      pointer_modulo_enable_bit_q <= {NPTR{1'b0}};
      modsize_q <= `DCO_RST_MODSIZE;
      step_q <= 7'h00;
      ptr_bank_q <= 16'h0000;
      instr_q <= 32'h00000000;
      exec_q <= 1'b0;
      last_cond_q <= 1'b0;
      exec_cnt_q <= 8'h00;
      ctx_cnt_q <= 8'h00;
      for (k = 0; k < NPTR; k = k + 1)
        address_pointer_q[k] <= 16'h0000;
      for (k = 0; k < 2; k = k + 1)
      begin
        acc_hi_q[k] <= 16'h0000;
        acc_lo_q[k] <= 16'h0000;
        accum_extension_bits_q[k] <= {EXT_W{1'b0}};
      end
    end
    else
    begin
      exec_q <= 1'b0;
      if (do_wr)
      begin
        case (awaddr_q)
          `DCO_ADDR_INSTR:
          begin
            instr_q <= merge(instr_q, wd, wstrb_q);
            exec_q <= 1'b1;
          end
          `DCO_ADDR_FLAGS: flags_q <= wstrb_q[0] ? wd[7:0] : flags_q;
          `DCO_ADDR_FLAGCFG: flagcfg_q <= cfg_mrg[23:0];
          `DCO_ADDR_MODCFG:
          begin
            if (wstrb_q[0])
              pointer_modulo_enable_bit_q <= wd[NPTR-1:0];
            if (wstrb_q[1] || wstrb_q[2])
              modsize_q <= wd[16:8];
            if (wstrb_q[3])
              step_q <= wd[30:24];
          end
          `DCO_ADDR_ACC0_HL:
          begin
            acc_hi_q[0] <= acc0_mrg[31:16];
            acc_lo_q[0] <= acc0_mrg[15:0];
          end
          `DCO_ADDR_ACC0_EXT:
            accum_extension_bits_q[0] <= wd[EXT_W-1:0];
          `DCO_ADDR_ACC1_HL:
          begin
            acc_hi_q[1] <= acc1_mrg[31:16];
            acc_lo_q[1] <= acc1_mrg[15:0];
          end
          `DCO_ADDR_ACC1_EXT:
            accum_extension_bits_q[1] <= wd[EXT_W-1:0];
          `DCO_ADDR_SHADOW: shadow_q <= wstrb_q[0] ? wd[7:0] : shadow_q;
          default:
            if (wr_ptr && wr_idx < NPTR)
              address_pointer_q[wr_idx] <= wd[15:0];
        endcase
      end
      if (exec_q)
      begin
        last_cond_q <= cond_true;
        // a false condition skips every architectural update except last_cond_q
        if (cond_true)
        begin
          exec_cnt_q <= exec_cnt_q + 8'h01;
          case (op)
            // keep-extension option leaves the extension bits alone
            `DCO_OP_MOVH:
            begin
              acc_hi_q[sel[0]] <= data;
              if (!option)
                accum_extension_bits_q[sel[0]] <= {EXT_W{data[15]}};
            end
            // no option: plain return, nothing swapped
            `DCO_OP_RETI:
              if (option)
              begin
                flags_q <= shadow_q;
                shadow_q <= flags_q;
                address_pointer_q[0] <= ptr_bank_q;
                ptr_bank_q <= address_pointer_q[0];
                ctx_cnt_q <= ctx_cnt_q + 8'h01;
              end
            `DCO_OP_MODR:
              if (sel < NPTR)
                address_pointer_q[sel] <= ptr_next;
            `DCO_OP_FLAGS:
              flags_q <= upd_flags(flags_q, flagcfg_q, data);
            default:
              exec_cnt_q <= exec_cnt_q + 8'h01;
          endcase
        end
      end
    end
  end

  // axi read side
  wire [7:0] rd_off;
  assign rd_off = s_axi_araddr - `DCO_ADDR_PTR_BASE;
  reg [31:0] rd_val;
  always @*
  begin
    rd_val = 32'h00000000;
    case (s_axi_araddr)
      `DCO_ADDR_INSTR: rd_val = instr_q;
      `DCO_ADDR_FLAGS: rd_val = {24'h000000, flags_q};
      `DCO_ADDR_FLAGCFG: rd_val = {8'h00, flagcfg_q};
      `DCO_ADDR_MODCFG: rd_val = {1'b0, step_q, 7'h00, modsize_q,
        {(8-NPTR){1'b0}}, pointer_modulo_enable_bit_q};
      `DCO_ADDR_STATE: rd_val = {ctx_cnt_q, exec_cnt_q, 5'h00, pin1_q,
        pin0_q, last_cond_q, 7'h00, exec_q};
      `DCO_ADDR_ACC0_HL: rd_val = {acc_hi_q[0], acc_lo_q[0]};
      `DCO_ADDR_ACC0_EXT: rd_val = {{(32-EXT_W){1'b0}},
        accum_extension_bits_q[0]};
      `DCO_ADDR_ACC1_HL: rd_val = {acc_hi_q[1], acc_lo_q[1]};
      `DCO_ADDR_ACC1_EXT: rd_val = {{(32-EXT_W){1'b0}},
        accum_extension_bits_q[1]};
      `DCO_ADDR_SHADOW: rd_val = {24'h000000, shadow_q};
      default:
        if (mapped(s_axi_araddr) && rd_off[4:2] < NPTR)
          rd_val = {16'h0000, address_pointer_q[rd_off[4:2]]};
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DCO_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= mapped(s_axi_araddr) ? `DCO_RESP_OKAY :
          `DCO_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// file: test/dco_top_properties.sv
// bus handshake properties of the decode block
`timescale 1ns/1ps
module dco_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  aw_busy_a: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("write address taken while busy");
  b_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  r_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write side not idle after answer");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("read side not idle");
  ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  b_cause_a: assert property ($rose(s_axi_bvalid) |->
    !s_axi_awready && !s_axi_wready)
    else $error("write answer without request");
  b_timely_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
endmodule

// file: test/tb.sv
// self-checking bench for the condition and option decode block
`timescale 1ns/1ps
`include "dco_defs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) \
  begin fails++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, p0 = 0, p1 = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic [33:0] rq[$];
  logic [31:0] mq[$];
  logic [1:0] bq[$];
  logic [33:0] got, want;
  int fails = 0, n_compared = 0;
  logic [31:0] seed = 32'h410D;
  logic [7:0] cnt = 0, ctx = 0;
  logic [15:0] hb = 0;
  always #2 aclk = ~aclk;
  dco_top #(.EXT_W(4), .NPTR(6)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .user_input_pin_zero(p0),
    .user_input_pin_one(p1));
  function [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function ce(input [3:0] c, input [7:0] f, input z0, input z1);
    case (c)
      `DCO_C_TRUE: ce = 1'b1;
      `DCO_C_ZERO: ce = f[0];
      `DCO_C_NZERO: ce = !f[0];
      `DCO_C_POS: ce = !f[1] && !f[0];
      `DCO_C_NNEG: ce = !f[1];
      `DCO_C_NEG: ce = f[1];
      `DCO_C_NPOS: ce = f[1] || f[0];
      `DCO_C_NNORM: ce = !f[2];
      `DCO_C_OVF: ce = f[3];
      `DCO_C_CARRY: ce = f[4];
      `DCO_C_EXT: ce = f[5];
      `DCO_C_LIM: ce = f[6];
      `DCO_C_RCLR: ce = !f[7];
      `DCO_C_PIN0_LO: ce = !z0;
      `DCO_C_PIN0_HI: ce = z0;
      default: ce = z1;
    endcase
  endfunction
  function [7:0] fexp(input [7:0] o, input [23:0] c, input [15:0] r);
    logic a;
    for (int k = 0; k < 8; k++)
    begin
      a = k == 0 ? r == 0 : k == 1 ? r[15] :
        k == 2 ? (r == 0 || (r[15] ^ r[14])) : c[16 + k];
      case (c[2 * k +: 2])
        `DCO_FM_KEEP: fexp[k] = o[k];
        `DCO_FM_AFFECT: fexp[k] = a;
        `DCO_FM_CLR: fexp[k] = 1'b0;
        default: fexp[k] = 1'b1;
      endcase
    end
  endfunction
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // flags, not the valids, end the loop: the valids' updates are pending
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      aw |= s_axi_awready;
      w |= s_axi_wready;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] e, input [31:0] m, input [1:0] r);
    rq.push_back({r, e & m});
    mq.push_back(m);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  // runs one instruction, then checks status against the tracked counts
  task ex(input [3:0] c, input [2:0] op, input [2:0] sel, input o,
    input [1:0] k, input [15:0] d, input t);
    wr(`DCO_ADDR_INSTR, {d, 3'h0, k, o, sel, op, c}, `DCO_RESP_OKAY);
    @(posedge aclk);
    if (t)
      cnt++;
    if (t && op == `DCO_OP_RETI && o)
      ctx++;
    rd(`DCO_ADDR_STATE, {ctx, cnt, 5'h0, p1, p0, t, 8'h00}, 32'hFFFF0701,
      `DCO_RESP_OKAY);
  endtask
  task tally_and_finish();
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
    begin
      got = {s_axi_rresp, s_axi_rdata & mq.pop_front()};
      want = rq.pop_front();
      `CHK(got, want)
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      got = {32'h0, s_axi_bresp};
      want = {32'h0, bq.pop_front()};
      `CHK(got, want)
    end
  end
  initial
  begin
    #200000;
    fails++;
    tally_and_finish();
  end
  initial
  begin
    logic [31:0] f, c, d, e;
    logic [7:0] pa;
    int p;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`DCO_ADDR_FLAGS, 0, 32'hFF, `DCO_RESP_OKAY);
    rd(8'h30, 0, 32'hFFFFFFFF, `DCO_RESP_SLVERR);
    wr(8'h30, 32'h1, `DCO_RESP_SLVERR);
    for (int i = 0; i < 48; i++)
    begin
      f = rnd();
      p0 <= f[8];
      p1 <= f[9];
      wr(`DCO_ADDR_FLAGS, f[7:0], `DCO_RESP_OKAY);
      ex(i[3:0], `DCO_OP_NOP, 0, 0, 0, 0, ce(i[3:0], f[7:0], f[8], f[9]));
    end
    // pin one held low makes its code a reliable false condition
    p0 <= 1'b0;
    p1 <= 1'b0;
    for (int i = 0; i < 24; i++)
    begin
      f = rnd();
      c = rnd();
      d = rnd();
      wr(`DCO_ADDR_FLAGS, f[7:0], `DCO_RESP_OKAY);
      wr(`DCO_ADDR_FLAGCFG, c[23:0], `DCO_RESP_OKAY);
      ex(i[0] ? `DCO_C_TRUE : `DCO_C_PIN1_HI, `DCO_OP_FLAGS, 0, 0, 0, d, i[0]);
      rd(`DCO_ADDR_FLAGS, i[0] ? fexp(f[7:0], c[23:0], d[15:0]) : f[7:0],
        32'hFF, `DCO_RESP_OKAY);
    end
    wr(`DCO_ADDR_FLAGCFG, 0, `DCO_RESP_OKAY);
    for (int i = 0; i < 6; i++)
    begin
      f = rnd();
      e = rnd();
      d = rnd();
      pa = i[0] ? `DCO_ADDR_ACC1_HL : `DCO_ADDR_ACC0_HL;
      wr(pa + 8'h04, f, `DCO_RESP_OKAY);
      wr(pa, e, `DCO_RESP_OKAY);
      ex(i < 4 ? `DCO_C_TRUE : `DCO_C_PIN1_HI, `DCO_OP_MOVH, {2'b0, i[0]},
        i[1], 0, d[15:0], i < 4);
      rd(pa, i < 4 ? {d[15:0], e[15:0]} : e, 32'hFFFFFFFF,
        `DCO_RESP_OKAY);
      rd(pa + 8'h04, (i < 4 && !i[1]) ? {4{d[15]}} : f[3:0], 32'hF,
        `DCO_RESP_OKAY);
    end
    for (int o = 0; o < 2; o++)
    begin
      f = rnd();
      wr(`DCO_ADDR_FLAGS, f[7:0], `DCO_RESP_OKAY);
      wr(`DCO_ADDR_SHADOW, f[15:8], `DCO_RESP_OKAY);
      wr(`DCO_ADDR_PTR_BASE, f[31:16], `DCO_RESP_OKAY);
      ex(`DCO_C_TRUE, `DCO_OP_RETI, 0, o[0], 0, 0, 1'b1);
      rd(`DCO_ADDR_FLAGS, o ? f[15:8] : f[7:0], 32'hFF,
        `DCO_RESP_OKAY);
      rd(`DCO_ADDR_SHADOW, o ? f[7:0] : f[15:8], 32'hFF,
        `DCO_RESP_OKAY);
      rd(`DCO_ADDR_PTR_BASE, o ? hb : f[31:16], 32'hFFFF,
        `DCO_RESP_OKAY);
      if (o)
        hb = f[31:16];
    end
    // wrap at both ends of a 16-entry window, with each enable and bypass
    for (int j = 0; j < 8; j++)
    begin
      p = rnd() % 6;
      c = 6'h01 << p;
      wr(`DCO_ADDR_MODCFG, {15'h0, 9'h010, 2'h0, j[0] ? c[5:0] : ~c[5:0]},
        `DCO_RESP_OKAY);
      pa = `DCO_ADDR_PTR_BASE + 8'(4 * p);
      wr(pa, j[2] ? 32'hA200 : 32'hA20F, `DCO_RESP_OKAY);
      ex(`DCO_C_TRUE, `DCO_OP_MODR, p[2:0], j[1],
        j[2] ? `DCO_MOD_DEC : `DCO_MOD_INC, 0, 1'b1);
      d = j[2] ? (j[0] && !j[1] ? 32'hA20F : 32'hA1FF) :
        (j[0] && !j[1] ? 32'hA200 : 32'hA210);
      rd(pa, d, 32'hFFFF, `DCO_RESP_OKAY);
    end
    // signed step of -3 wrapping below zero, bypassed, and no modify
    wr(`DCO_ADDR_MODCFG, 32'h7D001001, `DCO_RESP_OKAY);
    for (int j = 0; j < 3; j++)
    begin
      wr(`DCO_ADDR_PTR_BASE, 32'hA201, `DCO_RESP_OKAY);
      ex(`DCO_C_TRUE, `DCO_OP_MODR, 0, j == 1,
        j == 2 ? `DCO_MOD_NONE : `DCO_MOD_STEP, 0, 1'b1);
      d = j == 2 ? 32'hA201 : (j == 1 ? 32'hA1FE : 32'hA20E);
      rd(`DCO_ADDR_PTR_BASE, d, 32'hFFFF, `DCO_RESP_OKAY);
    end
    tally_and_finish();
  end
endmodule
bind dco_top dco_chk chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
